// ### hw/ssia_pkg.sv
// Summary of operation
// - Status word reached as two bytes
// - Writing one clears a set cause flag
// - Interrupt holds while any cause pending and global mask clear
// - Acknowledging a clear flag does nothing
// - Zero bits in acknowledge change nothing
// - Events latched, interrupt is a level
// - Several causes may be set together
// - Bit 15 set on command done
// - Optional bit 15 on bad transmit, first variant only
// - Bit 14 set on frame or header
// - Bit 13 on leaving active or entering idle
// - Bit 12 when receive unit leaves ready
// - Bit 11 on management done if enabled
// - Bit 10 is software requested cause
// - Bit 8 pause frame, later variants only
// - Bits 9, 1:0 reserved, read zero
// - Bits 7:6 give command unit state
// - Bits 5:2 give receive unit state
// - Unit state fields may lag commands
// - New event while asserted adds none
// - Global mask keeps interrupt pin off
package ssia_pkg;

    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int CAUSE_CMD_DONE  = 15;
    localparam int CAUSE_FRAME     = 14;
    localparam int CAUSE_CMD_INACT = 13;
    localparam int CAUSE_RX_NRDY   = 12;
    localparam int CAUSE_MGMT_DONE = 11;
    localparam int CAUSE_SW_REQ    = 10;
    localparam int CAUSE_RSVD      = 9;
    localparam int CAUSE_PAUSE     = 8;
    localparam int CAUSE_BYTE_LSB  = 8;
    localparam int CAUSE_BYTE_W    = 8;
    localparam int CMD_STATE_LSB   = 6;
    localparam int RCV_STATE_LSB   = 2;
    localparam logic [7:0]  CAUSE_RESET  = 8'h00;
    localparam logic [7:0]  CAUSE_IMPL   = 8'hFD; // Bit 9 reserved
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Unit state encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CMD_IDLE      = 2'h0;
    localparam logic [1:0] CMD_SUSPENDED = 2'h1;
    localparam logic [1:0] CMD_LOW_ACT   = 2'h2;
    localparam logic [1:0] CMD_HIGH_ACT  = 2'h3;
    localparam logic [3:0] RCV_IDLE      = 4'h0;
    localparam logic [3:0] RCV_SUSPENDED = 4'h1;
    localparam logic [3:0] RCV_NO_RES    = 4'h2;
    localparam logic [3:0] RCV_READY     = 4'h4;

    // Cause events from the units, one-cycle pulses
    typedef struct packed {
        logic cmd_done;
        logic tx_not_ok;
        logic frame_done;
        logic header_done;
        logic rx_abort;
        logic rx_no_res;
        logic rx_susp_fill;
        logic mgmt_done;
        logic pause_frame;
    } ssia_events_t;

    // Byte-lane register access
    typedef struct packed {
        logic       wr_hi;
        logic [7:0] wdata_hi;
    } ssia_ack_t;

endpackage

// ### hw/ssia_status.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Status word with latched interrupt causes
// ----------------------------------------------------------------
module ssia_status
    import ssia_pkg::*;
#(
    parameter int GENERATION = 2
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         srst,
    // Acknowledge byte write
    input  wire ssia_ack_t    ack,
    // Cause events and unit states
    input  wire ssia_events_t ev,
    input  wire logic [1:0]   command_unit_state,
    input  wire logic [3:0]   receive_unit_state,
    input  wire logic         sw_irq_req,
    // Configuration
    input  wire logic         cfg_bad_tx_en,
    input  wire logic         cfg_idle_only,
    input  wire logic         cfg_header_mode,
    input  wire logic         mgmt_irq_en,
    input  wire logic         global_mask,
    // Status and interrupt
    output logic [15:0]       status_word,
    output logic              irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // First generation is the oldest variant
    if (GENERATION < 1) begin : g_bad_gen
        $error("GENERATION must be at least 1");
    end
    // Cause byte fills the upper half of the word
    if (CAUSE_BYTE_W + CAUSE_BYTE_LSB != 16) begin : g_bad_layout
        $error("cause byte does not fit the status word");
    end
    // Reserved cause position is never implemented
    if (CAUSE_IMPL[CAUSE_RSVD-CAUSE_BYTE_LSB]) begin : g_bad_rsvd
        $error("reserved cause position marked as implemented");
    end
    // Reset value holds only implemented causes
    if ((CAUSE_RESET & ~CAUSE_IMPL) != 8'h00) begin : g_bad_reset
        $error("cause reset value sets unimplemented bits");
    end
    // State fields sit side by side above the low zeros
    if ((CMD_STATE_LSB != RCV_STATE_LSB + 4)
        || (RCV_STATE_LSB != 2)) begin : g_bad_fields
        $error("unit state fields misplaced");
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Command unit is running one of its queues
    function automatic logic cmd_active(input logic [1:0] state);
        cmd_active = (state == CMD_LOW_ACT)
                     || (state == CMD_HIGH_ACT);
    endfunction

    // Command unit moved out of a running queue
    function automatic logic cmd_left_active(
        input logic [1:0] prev,
        input logic [1:0] now
    );
        cmd_left_active = cmd_active(prev) && !cmd_active(now);
    endfunction

    // Command unit arrived in idle from any other state
    function automatic logic cmd_entered_idle(
        input logic [1:0] prev,
        input logic [1:0] now
    );
        cmd_entered_idle = (prev != CMD_IDLE) && (now == CMD_IDLE);
    endfunction

    // Receive unit moved out of ready
    function automatic logic rcv_left_ready(
        input logic [3:0] prev,
        input logic [3:0] now
    );
        rcv_left_ready = (prev == RCV_READY) && (now != RCV_READY);
    endfunction

    // Ones in an accepted write select flags to clear
    function automatic logic [7:0] ack_mask(
        input logic       strobe,
        input logic [7:0] bits
    );
        ack_mask = strobe ? bits : 8'h00;
    endfunction

    // Next value of one flag; a new event beats a clear
    function automatic logic next_flag(
        input logic held,
        input logic clear,
        input logic set
    );
        next_flag = set || (held && !clear);
    endfunction

    // Whole status word from its three parts
    function automatic logic [15:0] pack_status(
        input logic [7:0] causes,
        input logic [1:0] cmd,
        input logic [3:0] rcv
    );
        pack_status = {causes, cmd, rcv, 2'h0};
    endfunction

    // ------------------------------------------------------------
    // Registers and named wires
    // ------------------------------------------------------------
    // Latched state
    logic [7:0]  cause_q;
    logic [1:0]  cmd_prev_q;
    logic [3:0]  rcv_prev_q;
    // Next values
    logic [7:0]  cause_d;
    logic [15:0] status_d;
    logic        irq_d;
    logic [7:0]  set_vec;
    logic [7:0]  ack_vec;
    // Command and receive transitions
    logic        cmd_left;
    logic        cmd_to_idle;
    logic        cmd_event;
    logic        rcv_left;
    logic        rcv_event;
    // Decoded events
    logic        done_hit;
    logic        bad_tx_hit;
    logic        frame_hit;
    logic        mgmt_hit;
    logic        soft_hit;
    logic        pause_hit;
    logic        any_pending;

    // Interrupt line state, one-hot
    typedef enum logic [1:0] {
        IRQ_QUIET  = 2'h1,
        IRQ_RAISED = 2'h2
    } ssia_irq_state_t;
    ssia_irq_state_t irq_state_q;
    ssia_irq_state_t irq_state_d;

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    // Command done, and failed transmit on the first variant only
    assign done_hit    = ev.cmd_done;
    assign bad_tx_hit  = (GENERATION == 1) && cfg_bad_tx_en
                         && ev.tx_not_ok;
    // Whole frame, or header alone in header mode
    assign frame_hit   = ev.frame_done
                         || (cfg_header_mode && ev.header_done);
    // Leaving a queue, or entering idle, as configured
    assign cmd_left    = cmd_left_active(cmd_prev_q, command_unit_state);
    assign cmd_to_idle = cmd_entered_idle(cmd_prev_q, command_unit_state);
    assign cmd_event   = cfg_idle_only ? cmd_to_idle : cmd_left;
    // Receive unit left ready, by state change or a reported reason
    assign rcv_left    = rcv_left_ready(rcv_prev_q, receive_unit_state);
    assign rcv_event   = rcv_left || ev.rx_abort || ev.rx_no_res
                         || ev.rx_susp_fill;
    // Management cycle done, only while enabled
    assign mgmt_hit    = ev.mgmt_done && mgmt_irq_en;
    // Software asks for a fresh service pass
    assign soft_hit    = sw_irq_req;
    // Pause frames exist from the second variant on
    assign pause_hit   = (GENERATION >= 2) && ev.pause_frame;

    // ------------------------------------------------------------
    // Cause set vector
    // ------------------------------------------------------------
    // Command done, or failed transmit where enabled
    assign set_vec[CAUSE_CMD_DONE-CAUSE_BYTE_LSB]  = done_hit || bad_tx_hit;

    // Frame or header received
    assign set_vec[CAUSE_FRAME-CAUSE_BYTE_LSB]     = frame_hit;

    // Command unit left active or entered idle
    assign set_vec[CAUSE_CMD_INACT-CAUSE_BYTE_LSB] = cmd_event;

    // Receive unit no longer ready
    assign set_vec[CAUSE_RX_NRDY-CAUSE_BYTE_LSB]   = rcv_event;

    // Management cycle finished
    assign set_vec[CAUSE_MGMT_DONE-CAUSE_BYTE_LSB] = mgmt_hit;

    // Software request
    assign set_vec[CAUSE_SW_REQ-CAUSE_BYTE_LSB]    = soft_hit;

    // Reserved position never sets
    assign set_vec[CAUSE_RSVD-CAUSE_BYTE_LSB]      = 1'b0;

    // Pause frame received
    assign set_vec[CAUSE_PAUSE-CAUSE_BYTE_LSB]     = pause_hit;

    // ------------------------------------------------------------
    // Acknowledge and next flags
    // ------------------------------------------------------------
    // Only ones clear; zeros and clear flags stay as they are
    assign ack_vec = ack_mask(ack.wr_hi, ack.wdata_hi);
    // Each flag on its own; set beats clear in one cycle
    for (genvar i = 0; i < CAUSE_BYTE_W; i++) begin : g_flag
        assign cause_d[i] = CAUSE_IMPL[i]
                            && next_flag(cause_q[i], ack_vec[i],
                                         set_vec[i]);
    end

    // ------------------------------------------------------------
    // Pending summary
    // ------------------------------------------------------------
    // Any latched cause asks for service
    assign any_pending = |cause_d;

    // ------------------------------------------------------------
    // Next status word
    // ------------------------------------------------------------
    // Upper byte causes, lower byte unit states as reported
    assign status_d = pack_status(cause_d, command_unit_state,
                                  receive_unit_state);
    // States pass through unfiltered; the only lag added here is the one output register cycle

    // ------------------------------------------------------------
    // Interrupt line state
    // ------------------------------------------------------------
    // Raised while pending and unmasked; new events add no pulse
    always_comb begin
        irq_state_d = IRQ_QUIET;
        case (irq_state_q)
            IRQ_QUIET: begin
                if (any_pending && !global_mask) begin
                    irq_state_d = IRQ_RAISED;
                end
            end
            IRQ_RAISED: begin
                if (any_pending && !global_mask) begin
                    irq_state_d = IRQ_RAISED;
                end
            end
            default: begin
                irq_state_d = IRQ_QUIET;
            end
        endcase
    end
    // Line is a level, not a pulse
    assign irq_d = (irq_state_d == IRQ_RAISED);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Latched causes
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cause_q <= CAUSE_RESET;
        end else begin
            cause_q <= cause_d;
        end
    end

    // Previous command unit state
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmd_prev_q <= CMD_IDLE;
        end else begin
            cmd_prev_q <= command_unit_state;
        end
    end

    // Previous receive unit state
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rcv_prev_q <= RCV_IDLE;
        end else begin
            rcv_prev_q <= receive_unit_state;
        end
    end

    // Interrupt line state
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_state_q <= IRQ_QUIET;
        end else begin
            irq_state_q <= irq_state_d;
        end
    end

    // Status word output
    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_word <= STATUS_RESET;
        end else begin
            status_word <= status_d;
        end
    end

    // Interrupt output
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_d;
        end
    end

endmodule

// ### sim/ssia_status_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Status word checker
// ----------------------------------------
module ssia_status_chk
    import ssia_pkg::*;
(
    // Clock, reset and inputs
    input wire logic         core_clk, srst, sw_irq_req, mgmt_irq_en,
    input wire logic         global_mask,
    input wire ssia_ack_t    ack,
    input wire ssia_events_t ev,
    input wire logic [1:0]   command_unit_state,
    input wire logic [3:0]   receive_unit_state,
    // Outputs
    input wire logic [15:0]  status_word,
    input wire logic         irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Fields, causes and interrupt level
    rsvd_bits_a: assert property ((status_word & 16'h0203) == 16'h0)
        else $error("reserved bit set");
    cu_field_a: assert property (
        !$past(srst) |-> status_word[7:6] == $past(command_unit_state))
        else $error("command unit state wrong");
    ru_field_a: assert property (
        !$past(srst) |-> status_word[5:2] == $past(receive_unit_state))
        else $error("receive unit state wrong");
    cmd_set_a: assert property (ev.cmd_done |=> status_word[15])
        else $error("command done not latched");
    sw_set_a: assert property (sw_irq_req |=> status_word[10])
        else $error("software cause not latched");
    mgmt_set_a: assert property (
        ev.mgmt_done && mgmt_irq_en |=> status_word[11])
        else $error("management cause not latched");
    ack_clr_a: assert property (
        ack.wr_hi && ack.wdata_hi[6] && !ev.frame_done && !ev.header_done
        |=> !status_word[14]) else $error("frame cause not cleared");
    irq_off_a: assert property (
        status_word[15:8] == 8'h00 || $past(global_mask) |-> !irq)
        else $error("interrupt without cause");
    irq_on_a: assert property (
        !$past(srst) && !$past(global_mask) && |status_word[15:8] |-> irq)
        else $error("interrupt missing");
    irq_up_c: cover property ($rose(irq));
    ack_c: cover property (ack.wr_hi && |(ack.wdata_hi & status_word[15:8]));
    mask_c: cover property (global_mask && |status_word[15:8]);
endmodule

bind ssia_status ssia_status_chk u_chk (.core_clk(core_clk), .srst(srst),
    .ack(ack), .ev(ev), .command_unit_state(command_unit_state),
    .receive_unit_state(receive_unit_state),
    .sw_irq_req(sw_irq_req), .mgmt_irq_en(mgmt_irq_en),
    .global_mask(global_mask), .status_word(status_word), .irq(irq));

// ### sim/ssia_status_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module ssia_status_tb
    import ssia_pkg::*;
;
    // ----------------------------------------
    // Stimulus, expectation and checking
    // ----------------------------------------
    logic         core_clk = 1'h0, srst = 1'h1, sw_irq_req = 1'h0, irq, irq1;
    logic         bad_tx_en = 1'h0, idle_only = 1'h0, hdr_mode = 1'h0;
    logic         mgmt_en = 1'h0, gmask = 1'h0, quiet, exp_irq, exp_irq1;
    logic [1:0]   cmd = 2'h0, pcmd = 2'h0;
    logic [3:0]   rcv = 4'h0, prcv = 4'h0;
    logic [7:0]   exp_c = 8'h00, exp_c1 = 8'h00, clr;
    logic [15:0]  status_word, status_word1;
    ssia_ack_t    ack = '0;
    ssia_events_t ev = '0;
    int           failures = 0, num_checks = 0, cyc = 0;

    ssia_status #(.GENERATION(2)) dut (.core_clk(core_clk), .srst(srst),
        .ack(ack), .ev(ev), .command_unit_state(cmd),
        .receive_unit_state(rcv), .sw_irq_req(sw_irq_req),
        .cfg_bad_tx_en(bad_tx_en), .cfg_idle_only(idle_only),
        .cfg_header_mode(hdr_mode), .mgmt_irq_en(mgmt_en),
        .global_mask(gmask), .status_word(status_word), .irq(irq));
    // First variant: failed transmit option, no pause cause
    ssia_status #(.GENERATION(1)) dut1 (.core_clk(core_clk), .srst(srst),
        .ack(ack), .ev(ev), .command_unit_state(cmd),
        .receive_unit_state(rcv), .sw_irq_req(sw_irq_req),
        .cfg_bad_tx_en(bad_tx_en), .cfg_idle_only(idle_only),
        .cfg_header_mode(hdr_mode), .mgmt_irq_en(mgmt_en),
        .global_mask(gmask), .status_word(status_word1), .irq(irq1));

    // Cause bits set by this cycle's inputs for a given variant
    function automatic logic [7:0] set_bits(input int gen);
        set_bits = {ev.cmd_done | (gen == 1 && bad_tx_en && ev.tx_not_ok),
            ev.frame_done | (hdr_mode & ev.header_done),
            idle_only ? (pcmd != CMD_IDLE && cmd == CMD_IDLE)
                : (pcmd[1] & ~cmd[1]),
            ev.rx_abort | ev.rx_no_res | ev.rx_susp_fill
                | (prcv == RCV_READY && rcv != RCV_READY),
            ev.mgmt_done & mgmt_en, sw_irq_req, 1'h0,
            gen >= 2 && ev.pause_frame};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial forever #20 core_clk = ~core_clk;

    // Cycle ceiling
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            report_and_stop();
        end
    end

    // Random traffic, then a quiet tail acking everything
    initial begin
        void'($urandom(37));
        repeat (4) @(posedge core_clk);
        srst <= 1'h0;
        #1 `CHK("reset", 17'h0, {status_word, irq})
        `CHK("reset1", 17'h0, {status_word1, irq1})
        for (int i = 0; i < 2000; i++) begin
            @(posedge core_clk);
            quiet = i >= 1990;
            clr = ack.wr_hi ? ack.wdata_hi : 8'h00;
            exp_c = (exp_c & ~clr) | set_bits(2);
            exp_c1 = (exp_c1 & ~clr) | set_bits(1);
            exp_irq = |exp_c && !gmask;
            exp_irq1 = |exp_c1 && !gmask;
            pcmd = cmd;
            prcv = rcv;
            ev <= ssia_events_t'(quiet ? 9'h0
                : 9'($urandom & $urandom & $urandom));
            ack <= ssia_ack_t'(quiet ? 9'h1FF : 9'($urandom));
            sw_irq_req <= !quiet && $urandom % 8 == 0;
            gmask <= $urandom % 4 == 0;
            cmd <= 2'($urandom);
            rcv <= RCV_READY >> ($urandom % 4);
            {bad_tx_en, idle_only, hdr_mode, mgmt_en} <= 4'($urandom);
            #1;
            `CHK("causes", exp_c, status_word[15:8])
            `CHK("causes1", exp_c1, status_word1[15:8])
            `CHK("states", {pcmd, prcv, 2'h0}, status_word[7:0])
            `CHK("states1", {pcmd, prcv, 2'h0}, status_word1[7:0])
            `CHK("irq", exp_irq, irq)
            `CHK("irq1", exp_irq1, irq1)
        end
        report_and_stop();
    end
endmodule
